// *** core/lcd_aux_pkg.sv ***
// Constants and types shared by the auxiliary command decoder.
package lcd_aux_pkg;

	// ==========================================================
	// Register bus map
	localparam int ADR_W = 4;
	localparam logic [3:0] CMD_OFFS = 4'h0;
	localparam logic [3:0] STATUS_OFFS = 4'h4;
	localparam int CMD_A0_BIT = 8;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_IND_OFF = 8'hAC;
	localparam logic [7:0] CMD_IND_ON = 8'hAD;
	localparam logic [7:0] CMD_PS_STANDBY = 8'hA8;
	localparam logic [7:0] CMD_PS_SLEEP = 8'hA9;
	localparam logic [7:0] CMD_PS_RELEASE = 8'hE1;
	localparam logic [7:0] CMD_NLINE_RESET = 8'hE4;
	localparam logic [7:0] CMD_OSC_ON = 8'hAB;
	localparam logic [7:0] CMD_NOP = 8'hE3;
	localparam logic [7:0] CMD_RESET = 8'hE2;
	localparam logic [3:0] CMD_NLINE_SET_HI = 4'h3;
	localparam logic [3:0] CMD_TEST_HI = 4'hF;

	// ==========================================================
	// Indicator modes and reset values
	localparam logic [1:0] IND_OFF = 2'h0;
	localparam logic [1:0] IND_FAST = 2'h1;
	localparam logic [1:0] IND_SLOW = 2'h2;
	localparam logic [1:0] IND_STEADY = 2'h3;
	localparam logic [3:0] NLINE_CNT_RESET = 4'h0;

	// ==========================================================
	// Blink timing: a period is split into two equal halves
	localparam int CLK_HZ = 50000000;
	localparam int BLINK_FAST_MS = 500;
	localparam int BLINK_SLOW_MS = 1000;
	localparam int BLINK_FAST_HALF = CLK_HZ / 1000 * BLINK_FAST_MS / 2;
	localparam int BLINK_SLOW_HALF = CLK_HZ / 1000 * BLINK_SLOW_MS / 2;
	localparam int BLINK_CNT_W = 25;

	// ==========================================================
	// Status word bit positions
	localparam int ST_PEND_BIT = 0;
	localparam int ST_IND_LSB = 1;
	localparam int ST_NLINE_LSB = 3;
	localparam int ST_NLINE_EN_BIT = 7;
	localparam int ST_OSC_BIT = 8;
	localparam int ST_STANDBY_BIT = 9;
	localparam int ST_SLEEP_BIT = 10;
	localparam int ST_TEST_BIT = 11;

	typedef enum logic [1:0] {PS_RUN, PS_STANDBY, PS_SLEEP} ps_state_t;

endpackage : lcd_aux_pkg

// *** core/blink_divider.sv ***
// Divides the display clock into the indicator blink waveform.
`timescale 1ns/1ns
module blink_divider
	import lcd_aux_pkg::*;
#(
	parameter int FAST_HALF = BLINK_FAST_HALF,
	parameter int SLOW_HALF = BLINK_SLOW_HALF
)(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [1:0] mode_i,
	output logic            phase_o
);

	logic [BLINK_CNT_W-1:0] cnt_q;
	logic [BLINK_CNT_W-1:0] limit;

	assign limit = (mode_i == IND_SLOW)
		? BLINK_CNT_W'(SLOW_HALF - 1)
		: BLINK_CNT_W'(FAST_HALF - 1);

	// The counter only advances while the display clock runs, so the
	// blink freezes in sleep and keeps going in stand-by.
	always_ff @(posedge clk_i)
	begin
		if (rst_i) begin
			cnt_q <= '0;
			phase_o <= 1'b0;
		end else if (run_i) begin
			if (cnt_q >= limit) begin
				cnt_q <= '0;
				phase_o <= ~phase_o;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule : blink_divider

// *** core/power_save_ctrl.sv ***
// Power save state machine: run, stand-by and sleep.
`timescale 1ns/1ns
module power_save_ctrl
	import lcd_aux_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic enter_i,
	input  wire logic sleep_i,
	input  wire logic release_i,
	output ps_state_t state_o
);

	ps_state_t state_d;

	// Settings are held outside this machine, so leaving power save
	// brings back the prior operating state untouched.
	always_comb
	begin
		state_d = state_o;
		unique case (state_o)
			PS_RUN:
			begin
				if (enter_i)
					state_d = sleep_i ? PS_SLEEP : PS_STANDBY;
			end
			PS_STANDBY, PS_SLEEP:
			begin
				if (release_i)
					state_d = PS_RUN;
				else if (enter_i)
					state_d = sleep_i ? PS_SLEEP : PS_STANDBY;
			end
			default: state_d = PS_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_o <= PS_RUN;
		else
			state_o <= state_d;
	end

endmodule : power_save_ctrl

// *** core/lcd_aux_command_decoder.sv ***
// Auxiliary display command decoder with a Wishbone command port.
//
// Summary of operation
// - indicator set loads two low bits only.
// - mode 01 blinks, half second period.
// - mode 10 blinks, one second period.
// - mode 11 keeps indicator steadily on.
// - power save: D0 0 stand-by, 1 sleep.
// - power save keeps settings, accepts data.
// - sleep stops oscillator and power supply.
// - sleep halts drive, outputs forced high.
// - stand-by stops supply, oscillator keeps running.
// - stand-by stops multiplex, indicator still driven.
// - power save drives display-off output low.
// - release restores state before power save.
// - count N gives N+1 reversal lines.
// - reversal reset keeps stored line count.
// - oscillator on needs master and internal.
// - nibble F enters test; reset/NOP leave.
// - after indicator on, only register set.
`timescale 1ns/1ns
module lcd_aux_command_decoder
	import lcd_aux_pkg::*;
#(
	parameter int FAST_HALF = lcd_aux_pkg::BLINK_FAST_HALF,
	parameter int SLOW_HALF = lcd_aux_pkg::BLINK_SLOW_HALF
)(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          hardware_reset_n_i,
	input  wire logic                          master_select_i,
	input  wire logic                          internal_osc_select_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [lcd_aux_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               display_off_output_n_o,
	output logic                               osc_enable_o,
	output logic                               power_supply_enable_o,
	output logic                               mux_drive_enable_o,
	output logic                               static_drive_enable_o,
	output logic                               seg_com_force_vdd_o,
	output logic                               indicator_o,
	output logic                               nline_enable_o,
	output logic      [3:0]                    nline_count_o,
	output logic                               test_mode_o,
	output logic                               ram_write_o,
	output logic      [7:0]                    ram_data_o
);

	import lcd_aux_pkg::*;

	// ==========================================================
	// Declarations
	logic       rst_int;
	logic       req;
	logic       cmd_wr;
	logic       a0;
	logic [7:0] code;
	logic       is_cmd;
	logic       accept;
	logic       ind_set;
	logic       osc_allowed;
	logic       clk_running;
	logic       blink_phase;
	logic       ind_level;
	logic       ps_enter;
	logic       ps_release;
	logic       is_test;
	logic       is_reset;
	logic       is_nop;
	logic       ind_pend_q;
	logic [1:0] ind_mode_q;
	logic [3:0] nline_cnt_q;
	logic       nline_en_q;
	logic       osc_on_q;
	logic       test_q;
	logic [31:0] status;
	ps_state_t  ps_state;

	// ==========================================================
	// Reset and bus request decode

	// The reset pin is sampled like any other synchronous input and
	// acts together with the system reset.
	assign rst_int = rst_i | ~hardware_reset_n_i;

	// A request is taken once; the cycle that raises ack is the one
	// in which a write has its effect.
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	assign cmd_wr = req & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == CMD_OFFS);

	// Bit eight carries the command or data select pin level.
	assign a0 = wb_dat_i[CMD_A0_BIT] & wb_sel_i[1];
	assign code = wb_dat_i[7:0];
	assign is_cmd = cmd_wr & ~a0;

	// ==========================================================
	// Command classification

	// While an indicator register set is awaited every other command
	// is swallowed, so a stray byte cannot be taken as a command.
	assign accept = is_cmd & ~ind_pend_q;
	assign ind_set = is_cmd & ind_pend_q;

	assign is_test = accept & (code[7:4] == CMD_TEST_HI);
	assign is_reset = accept & (code == CMD_RESET);
	assign is_nop = accept & (code == CMD_NOP);

	assign ps_enter = accept
		& ((code == CMD_PS_STANDBY) | (code == CMD_PS_SLEEP));
	assign ps_release = accept & (code == CMD_PS_RELEASE);

	assign osc_allowed = master_select_i & internal_osc_select_i;

	// ==========================================================
	// Wishbone slave

	// Every access is answered one cycle after it is seen; unmapped
	// addresses read zero and drop writes.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_comb
	begin
		status = '0;
		status[ST_PEND_BIT] = ind_pend_q;
		status[ST_IND_LSB +: 2] = ind_mode_q;
		status[ST_NLINE_LSB +: 4] = nline_cnt_q;
		status[ST_NLINE_EN_BIT] = nline_en_q;
		status[ST_OSC_BIT] = osc_on_q;
		status[ST_STANDBY_BIT] = (ps_state == PS_STANDBY);
		status[ST_SLEEP_BIT] = (ps_state == PS_SLEEP);
		status[ST_TEST_BIT] = test_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (req & ~wb_we_i & (wb_adr_i == STATUS_OFFS))
			wb_dat_o <= status;
		else
			wb_dat_o <= '0;
	end

	// ==========================================================
	// Display data path

	// Data bytes pass straight on to the display memory in every
	// power state; power save never blocks them.
	always_ff @(posedge clk_i)
	begin
		if (rst_int) begin
			ram_write_o <= 1'b0;
			ram_data_o <= '0;
		end else begin
			ram_write_o <= cmd_wr & a0;
			if (cmd_wr & a0)
				ram_data_o <= code;
		end
	end

	// ==========================================================
	// Static indicator

	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			ind_pend_q <= 1'b0;
		else if (ind_set)
			ind_pend_q <= 1'b0;
		else if (accept & (code == CMD_IND_ON))
			ind_pend_q <= 1'b1;
	end

	// The reset command also returns the indicator to off.
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			ind_mode_q <= IND_OFF;
		else if (ind_set)
			ind_mode_q <= code[1:0];
		else if (accept & (code == CMD_IND_OFF))
			ind_mode_q <= IND_OFF;
		else if (is_reset)
			ind_mode_q <= IND_OFF;
	end

	// The divider runs on whatever display clock is live: the
	// internal oscillator or an outside source when either select pin is low.
	assign clk_running = (osc_on_q | ~osc_allowed)
		& (ps_state != PS_SLEEP);

	blink_divider #(
		.FAST_HALF (FAST_HALF),
		.SLOW_HALF (SLOW_HALF)
	) u_blink (
		.clk_i   (clk_i),
		.rst_i   (rst_int),
		.run_i   (clk_running),
		.mode_i  (ind_mode_q),
		.phase_o (blink_phase)
	);

	always_comb
	begin
		unique case (ind_mode_q)
			IND_OFF:    ind_level = 1'b0;
			IND_FAST:   ind_level = blink_phase;
			IND_SLOW:   ind_level = blink_phase;
			IND_STEADY: ind_level = 1'b1;
		endcase
	end

	// ==========================================================
	// Power save

	power_save_ctrl u_ps (
		.clk_i     (clk_i),
		.rst_i     (rst_int),
		.enter_i   (ps_enter),
		.sleep_i   (code[0]),
		.release_i (ps_release),
		.state_o   (ps_state)
	);

	// ==========================================================
	// n-line reversal

	// The stored count is N; the panel reverses every N+1 lines.
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			nline_cnt_q <= NLINE_CNT_RESET;
		else if (accept & (code[7:4] == CMD_NLINE_SET_HI))
			nline_cnt_q <= code[3:0];
	end

	// A count of zero selects no reversal, so it leaves the drive in
	// plain frame alternation.
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			nline_en_q <= 1'b0;
		else if (accept & (code[7:4] == CMD_NLINE_SET_HI))
			nline_en_q <= (code[3:0] != NLINE_CNT_RESET);
		else if (accept & (code == CMD_NLINE_RESET))
			nline_en_q <= 1'b0;
	end

	// ==========================================================
	// Oscillator

	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			osc_on_q <= 1'b0;
		else if (accept & (code == CMD_OSC_ON) & osc_allowed)
			osc_on_q <= 1'b1;
	end

	// ==========================================================
	// Test mode

	// Test mode only flags the condition; it has no effect on
	// normal decoding here.
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			test_q <= 1'b0;
		else if (is_test)
			test_q <= 1'b1;
		else if (is_reset | is_nop)
			test_q <= 1'b0;
	end

	// ==========================================================
	// Registered outputs

	always_ff @(posedge clk_i)
	begin
		if (rst_int) begin
			osc_enable_o <= 1'b0;
			power_supply_enable_o <= 1'b1;
			display_off_output_n_o <= 1'b1;
		end else begin
			// Stand-by keeps the oscillator for the indicator.
			osc_enable_o <= osc_on_q
				& (ps_state != PS_SLEEP);
			power_supply_enable_o <=
				(ps_state == PS_RUN);
			display_off_output_n_o <=
				(ps_state == PS_RUN);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_int) begin
			mux_drive_enable_o <= 1'b1;
			static_drive_enable_o <= 1'b1;
			seg_com_force_vdd_o <= 1'b0;
			indicator_o <= 1'b0;
		end else begin
			mux_drive_enable_o <=
				(ps_state == PS_RUN);
			static_drive_enable_o <=
				(ps_state != PS_SLEEP);
			seg_com_force_vdd_o <=
				(ps_state != PS_RUN);
			indicator_o <= ind_level
				& (ps_state != PS_SLEEP);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_int) begin
			nline_enable_o <= 1'b0;
			nline_count_o <= NLINE_CNT_RESET;
			test_mode_o <= 1'b0;
		end else begin
			nline_enable_o <= nline_en_q;
			nline_count_o <= nline_cnt_q;
			test_mode_o <= test_q;
		end
	end

endmodule : lcd_aux_command_decoder

// *** dv/lcd_aux_host.sv ***
// Host bus master model issuing classic Wishbone cycles.
`timescale 1ns/1ns
module lcd_aux_host
	import lcd_aux_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          ack_i,
	output logic                               cyc_o,
	output logic                               stb_o,
	output logic                               we_o,
	output logic      [lcd_aux_pkg::ADR_W-1:0] adr_o,
	output logic      [3:0]                    sel_o,
	output logic      [31:0]                   dat_o
);
	int tmo = 0;

	initial
	begin
		{cyc_o, stb_o, we_o} = 3'h0;
		adr_o = 4'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o} <= {2'h3, w};
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 64);
		if (ack_i !== 1'b1)
			tmo++;
		{cyc_o, stb_o, we_o} <= 3'h0;
		// Released lines change so a stale value is never mistaken for data.
		adr_o <= ~a;
		dat_o <= ~d;
	endtask : xfer
endmodule : lcd_aux_host

// *** dv/lcd_aux_command_decoder_monitor.sv ***
// Port checker for the auxiliary command decoder.
`timescale 1ns/1ns
module lcd_aux_command_decoder_monitor
	import lcd_aux_pkg::*;
(
	input wire logic clk_i, rst_i, hardware_reset_n_i, master_select_i,
	input wire logic internal_osc_select_i, wb_cyc_i, wb_stb_i, wb_we_i,
	input wire logic [lcd_aux_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i, nline_count_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o, display_off_output_n_o, osc_enable_o,
	input wire logic power_supply_enable_o, mux_drive_enable_o,
	input wire logic static_drive_enable_o, seg_com_force_vdd_o,
	input wire logic indicator_o, nline_enable_o, test_mode_o, ram_write_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !hardware_reset_n_i);
	// ==========================================================
	// Command writes taken on the bus

	// Tracks the indicator-set wait as seen from the bus, so that the
	// byte which only loads the indicator is not taken as a command.
	logic cmd_take;
	logic pend_q;
	assign cmd_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
		&& wb_adr_i == CMD_OFFS && wb_sel_i[0]
		&& !(wb_dat_i[CMD_A0_BIT] && wb_sel_i[1]);
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !hardware_reset_n_i)
			pend_q <= 1'b0;
		else if (cmd_take)
			pend_q <= !pend_q && wb_dat_i[7:0] == CMD_IND_ON;
	end

	sequence s_wr;
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
			&& wb_adr_i == CMD_OFFS && wb_sel_i[1:0] == 2'h3;
	endsequence
	sequence s_op(logic [7:0] c);
		s_wr ##0 !wb_dat_i[CMD_A0_BIT] && !pend_q
			&& wb_dat_i[7:0] == c;
	endsequence

	a_ack_pulse:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack pulse wrong");
	a_data_pass:
	assert property (s_wr ##0 wb_dat_i[CMD_A0_BIT] |-> ##[1:3] ram_write_o)
		else $error("data byte not passed");
	a_test_entry:
	assert property (s_wr ##0 !wb_dat_i[CMD_A0_BIT] && !pend_q
		&& wb_dat_i[7:4] == CMD_TEST_HI |-> ##[1:3] test_mode_o)
		else $error("test mode not entered");
	a_test_exit:
	assert property (s_op(CMD_NOP) or s_op(CMD_RESET)
		|-> ##[1:3] !test_mode_o) else $error("test mode not left");
	a_sleep_stop:
	assert property (!static_drive_enable_o
		|-> !osc_enable_o && !power_supply_enable_o)
		else $error("sleep left clock or supply on");
	a_sleep_drive:
	assert property (!static_drive_enable_o |-> seg_com_force_vdd_o
		&& !mux_drive_enable_o && !indicator_o) else $error("sleep drive");
	a_standby_state:
	assert property (seg_com_force_vdd_o && static_drive_enable_o
		|-> !power_supply_enable_o && !mux_drive_enable_o)
		else $error("stand-by left supply or multiplex on");
	a_dof_follow:
	assert property (seg_com_force_vdd_o ^ display_off_output_n_o)
		else $error("display-off output wrong");
	a_nline_keep:
	assert property (s_op(CMD_NLINE_RESET) |-> ##2 !nline_enable_o
		&& nline_count_o == $past(nline_count_o, 2))
		else $error("reversal count changed");
	a_osc_gate:
	assert property ($rose(osc_enable_o)
		|-> master_select_i && internal_osc_select_i)
		else $error("oscillator started without both pins");
	a_release_run:
	assert property (s_op(CMD_PS_RELEASE) |-> ##[1:3]
		power_supply_enable_o && !seg_com_force_vdd_o)
		else $error("release did not restore run");
endmodule : lcd_aux_command_decoder_monitor

bind lcd_aux_command_decoder lcd_aux_command_decoder_monitor u_mon (.*);

// *** dv/lcd_aux_command_decoder_test.sv ***
// Self-checking bench for the auxiliary command decoder.
`timescale 1ns/1ns
module lcd_aux_command_decoder_test;
	import lcd_aux_pkg::*;
	// Short blink halves keep the run brief.
	localparam int FH = 4;
	localparam int SH = 8;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        hw_n = 1'b1;
	logic        msel = 1'b0;
	logic        isel = 1'b0;
	logic        cyc, stb, we, ack, dofn, osc, psu, mux, sdrv, fvdd;
	logic        ind, nlen, tst, rwr;
	logic [3:0]  adr, sel, ncnt, nn;
	logic [31:0] dw, dr;
	logic [7:0]  rdat, b;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          fail_count = 0;
	int          comparisons = 0;
	int          n;

	initial
		forever #10 clk_i = ~clk_i;

	lcd_aux_command_decoder #(.FAST_HALF(FH), .SLOW_HALF(SH))
	u_lcd_aux_command_decoder (
		.clk_i(clk_i), .rst_i(rst_i), .hardware_reset_n_i(hw_n),
		.master_select_i(msel), .internal_osc_select_i(isel),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.display_off_output_n_o(dofn), .osc_enable_o(osc),
		.power_supply_enable_o(psu), .mux_drive_enable_o(mux),
		.static_drive_enable_o(sdrv), .seg_com_force_vdd_o(fvdd),
		.indicator_o(ind), .nline_enable_o(nlen), .nline_count_o(ncnt),
		.test_mode_o(tst), .ram_write_o(rwr), .ram_data_o(rdat));
	lcd_aux_host u_lcd_aux_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));

	// ==========================================================
	// Checking and bus helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic tally_and_finish;
		fail_count += u_lcd_aux_host.tmo;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	function automatic logic [31:0] bit_at(input int p);
		return 32'h1 << p;
	endfunction : bit_at

	task automatic wr(input logic [7:0] v, input logic a0);
		u_lcd_aux_host.xfer(1'b1, CMD_OFFS, 4'hF, {23'h0, a0, v});
		repeat (2) @(negedge clk_i);
		if (u_lcd_aux_host.tmo != 0)
			tally_and_finish;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] m, v);
		msk_q.push_back(m);
		exp_q.push_back(v);
		u_lcd_aux_host.xfer(1'b0, a, 4'hF, 32'h0);
		if (u_lcd_aux_host.tmo != 0)
			tally_and_finish;
	endtask : rd

	// Cycles between two successive indicator edges.
	task automatic gap(output int c);
		logic v;
		v = ind;
		for (int k = 0; k < 99 && ind === v; k++)
			@(negedge clk_i);
		v = ind;
		c = 0;
		while (c < 99 && ind === v)
		begin
			@(negedge clk_i);
			c++;
		end
	endtask : gap

	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			chk(dr & msk_q.pop_front(), exp_q.pop_front());

	initial
	begin
		#1000000;
		fail_count++;
		tally_and_finish;
	end

	initial
	begin
		b = 8'($urandom(32'h8074D79E));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({dofn, osc, psu, mux, sdrv, fvdd, ind, tst}, 8'hB8);
		for (int p = 0; p < 4; p++)
		begin
			@(posedge clk_i) {msel, isel} <= 2'(p);
			wr(CMD_OSC_ON, 1'b0);
			chk(osc, p == 3);
		end
		rd(4'h8, 32'hFFFF_FFFF, 32'h0);
		u_lcd_aux_host.xfer(1'b1, 4'hC, 4'hF, 32'hF0);
		u_lcd_aux_host.xfer(1'b1, CMD_OFFS, 4'hE, 32'hF0);
		repeat (2) @(negedge clk_i);
		chk(tst, 1'b0);
		for (int m = 2; m < 6; m++)
		begin
			wr(CMD_IND_ON, 1'b0);
			rd(STATUS_OFFS, 32'h1, 32'h1);
			// A command byte in the A8 to AF range here only loads the indicator register.
			b = {CMD_PS_SLEEP[7:3], 1'($urandom), 2'(m)};
			wr(b, 1'b0);
			rd(STATUS_OFFS, 32'h7 | bit_at(ST_SLEEP_BIT)
				| bit_at(ST_STANDBY_BIT),
				32'(b[1:0]) << ST_IND_LSB);
			if (b[1] ^ b[0])
			begin
				gap(n);
				chk(n, b[0] ? FH : SH);
			end
			else
			begin
				repeat (12) @(negedge clk_i);
				chk(ind, b[0]);
			end
		end
		nn = 4'($urandom_range(15, 1));
		wr({CMD_NLINE_SET_HI, nn}, 1'b0);
		chk({nlen, ncnt}, {1'b1, nn});
		wr(CMD_PS_STANDBY, 1'b0);
		chk({dofn, osc, psu, mux, sdrv, fvdd}, 6'h13);
		gap(n);
		chk(n, FH);
		b = 8'($urandom);
		wr(b, 1'b1);
		chk(rdat, b);
		wr(CMD_PS_SLEEP, 1'b0);
		chk({dofn, osc, psu, mux, sdrv, fvdd, ind}, 7'h02);
		rd(STATUS_OFFS, bit_at(ST_SLEEP_BIT) | 32'hFF << ST_IND_LSB,
			bit_at(ST_SLEEP_BIT) | 32'(nn) << ST_NLINE_LSB
			| bit_at(ST_NLINE_EN_BIT) | bit_at(ST_IND_LSB)
			| bit_at(ST_OSC_BIT));
		wr(CMD_PS_RELEASE, 1'b0);
		chk({dofn, osc, psu, mux, sdrv, fvdd, nlen, ncnt},
			{6'h3E, 1'b1, nn});
		wr(CMD_NLINE_RESET, 1'b0);
		chk({nlen, ncnt}, {1'b0, nn});
		// Test entry is issued only here, never in normal traffic.
		for (int k = 0; k < 3; k++)
		begin
			wr({CMD_TEST_HI, 4'($urandom)}, 1'b0);
			chk(tst, 1'b1);
			if (k < 2)
				wr(k == 0 ? CMD_NOP : CMD_RESET, 1'b0);
			else
			begin
				@(posedge clk_i) hw_n <= 1'b0;
				repeat (2) @(posedge clk_i);
				hw_n <= 1'b1;
				repeat (2) @(negedge clk_i);
			end
			chk(tst, 1'b0);
		end
		// The indicator setting is written again after the upset.
		wr(CMD_IND_ON, 1'b0);
		wr(8'h03, 1'b0);
		chk(ind, 1'b1);
		wr(CMD_IND_OFF, 1'b0);
		chk(ind, 1'b0);
		tally_and_finish;
	end
endmodule : lcd_aux_command_decoder_test
